/* File: include/protection_threshold_cfg.svh */
/*
  Offsets, field positions, reset values and scale constants for the
  protection threshold register group.
  Assumes inclusion by bare name from design and bench files.
*/
`ifndef PROTECTION_THRESHOLD_CFG_SVH
`define PROTECTION_THRESHOLD_CFG_SVH

// Register offsets; control offset is not printed, chosen here
`define CTRL_OFFSET 8'h16
`define OTP_OFFSET 8'h17
`define HOT_OFFSET 8'h18

// Reset values
`define CTRL_RESET 8'h00
`define OTP_RESET 8'hA5
`define HOT_RESET 8'h8C
`define RDATA_RESET 8'h00
`define UNMAPPED_READ 8'h00
`define TRIP_MV_RESET 16'h0000
`define TEMP_RESET 9'h000

// Control field positions
`define REF_BIT 7
`define DELTA_HI 6
`define DELTA_LO 4
`define HOT_SRC_BIT 1
`define OTP_SRC_BIT 0
// Writable mask: reserved bits 3 and 2 clear
`define CTRL_WMASK 8'hF3

// Scales
`define DELTA_STEP_MV 16'd350
`define DELTA_OFF_CODE 3'h0
`define TEMP_OFFSET_C 9'sd40
`define HOT_OFF_CODE 8'h00

`endif

/* File: include/protection_threshold_pkg.sv */
/*
  Types shared by the protection threshold register group.
  Assumes the cfg header supplies all numeric constants.
*/
`default_nettype none
package protection_threshold_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic signed [8:0] temp_c_t;
  typedef logic [15:0] millivolt_t;
  typedef enum logic [2:0]
  {
    ACC_IDLE = 3'b001,
    ACC_WRITE = 3'b010,
    ACC_READ = 3'b100
  } access_state_t;
endpackage
`default_nettype wire

/* File: logic/threshold_store.sv */
/*
  Three-entry register store with registered read data.
  Assumes one write or read request per cycle from the main block.
*/
`timescale 1ns/100ps
`default_nettype none
`include "protection_threshold_cfg.svh"
module threshold_store
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Access
  input wire logic wr_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  // Contents
  output logic [7:0] rdata_out,
  output logic [7:0] ctrl_out,
  output logic [7:0] otp_out,
  output logic [7:0] hot_out
);
  import protection_threshold_pkg::*;

  reg_byte_t ctrl_q, ctrl_d, otp_q, otp_d, hot_q, hot_d, rdata_q, rdata_d;

  //////////////////////////////////////////////////////////////////////
  always_comb
  begin
    ctrl_d = ctrl_q;
    otp_d = otp_q;
    hot_d = hot_q;
    if (wr_en_in)
    begin
      if (addr_in == `CTRL_OFFSET)
        ctrl_d = wdata_in & `CTRL_WMASK;
      if (addr_in == `OTP_OFFSET)
        otp_d = wdata_in;
      if (addr_in == `HOT_OFFSET)
        hot_d = wdata_in;
    end
    case (addr_in)
      `CTRL_OFFSET: rdata_d = ctrl_q;
      `OTP_OFFSET: rdata_d = otp_q;
      `HOT_OFFSET: rdata_d = hot_q;
      default: rdata_d = `UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      ctrl_q <= `CTRL_RESET;
      otp_q <= `OTP_RESET;
      hot_q <= `HOT_RESET;
      rdata_q <= `RDATA_RESET;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      otp_q <= otp_d;
      hot_q <= hot_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_out = rdata_q;
  assign ctrl_out = ctrl_q;
  assign otp_out = otp_q;
  assign hot_out = hot_q;
endmodule
`default_nettype wire

/* File: logic/protection_threshold_regs.sv */
/*
  Protection threshold registers and derived trip settings.
  Assumes a serial management front end on clk_in presents decoded byte
  accesses; processor-side thresholds arrive synchronous to clk_in.
  Derived settings lag a register write by one further edge, so a
  downstream comparator sees the old threshold for one cycle.
*/
`timescale 1ns/100ps
`default_nettype none
`include "protection_threshold_cfg.svh"
// What this block does
// - Control bit 7 picks present or maximum voltage target as trip reference.
// - Bits 6:4 add code times 350 mV to reference; code zero disables delta.
// - Hot-warning threshold from processor side unless control bit 1 set.
// - Local over-temperature trip equals code minus 40 C; code resets A5h.
module protection_threshold_regs
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Register access
  input wire logic acc_valid_in,
  input wire logic acc_write_in,
  input wire logic [7:0] acc_addr_in,
  input wire logic [7:0] acc_wdata_in,
  output logic acc_rvalid_out,
  output logic [7:0] acc_rdata_out,
  // Voltage targets and processor-side thresholds
  input wire protection_threshold_pkg::millivolt_t voltage_target_in,
  input wire protection_threshold_pkg::millivolt_t voltage_target_maximum_in,
  input wire protection_threshold_pkg::temp_c_t proc_otp_c_in,
  input wire protection_threshold_pkg::temp_c_t proc_hot_c_in,
  input wire logic proc_hot_en_in,
  // Derived settings
  output protection_threshold_pkg::millivolt_t overvoltage_trip_mv_out,
  output logic overvoltage_delta_active_out,
  output protection_threshold_pkg::temp_c_t overtemp_trip_c_out,
  output protection_threshold_pkg::temp_c_t regulator_hot_warning_c_out,
  output logic regulator_hot_warning_en_out
);
  import protection_threshold_pkg::*;

  // Access sequencing
  access_state_t state_q;
  access_state_t state_d;
  logic rvalid_q;
  logic rvalid_d;
  // Stored register contents
  reg_byte_t ctrl;
  reg_byte_t otp_code;
  reg_byte_t hot_code;
  reg_byte_t rdata;
  // Control fields
  logic overvoltage_reference_select;
  logic [2:0] overvoltage_delta_code;
  logic hot_warning_source_select;
  logic otp_source_select;
  // Overvoltage trip
  millivolt_t ovp_q;
  millivolt_t ovp_d;
  logic dact_q;
  logic dact_d;
  // Over-temperature trip
  temp_c_t otp_q;
  temp_c_t otp_d;
  // Hot warning
  temp_c_t hot_q;
  temp_c_t hot_d;
  logic hot_en_q;
  logic hot_en_d;

  // Both temperature codes share one scale
  function automatic temp_c_t code_to_c(input reg_byte_t code);
    code_to_c = $signed({1'b0, code}) - `TEMP_OFFSET_C;
  endfunction

  // Delta code to millivolts; a 3-bit code times the step fits 16 bits
  function automatic millivolt_t delta_mv(input logic [2:0] code);
    delta_mv = 16'({13'h0000, code} * `DELTA_STEP_MV);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Register store; read data registered inside
  threshold_store u_store
  (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .wr_en_in(acc_valid_in && acc_write_in),
    .addr_in(acc_addr_in),
    .wdata_in(acc_wdata_in),
    .rdata_out(rdata),
    .ctrl_out(ctrl),
    .otp_out(otp_code),
    .hot_out(hot_code)
  );

  // Control field decode
  // reference field
  assign overvoltage_reference_select = ctrl[`REF_BIT];
  assign overvoltage_delta_code = ctrl[`DELTA_HI:`DELTA_LO];
  assign hot_warning_source_select = ctrl[`HOT_SRC_BIT];
  assign otp_source_select = ctrl[`OTP_SRC_BIT];

  //////////////////////////////////////////////////////////////////////
  // Access sequencing: read data valid one cycle after the store registers it
  always_comb
  begin
    state_d = ACC_IDLE;
    rvalid_d = 1'b0;
    case (state_q)
      ACC_IDLE, ACC_WRITE, ACC_READ:
      begin
        if (acc_valid_in)
          state_d = acc_write_in ? ACC_WRITE : ACC_READ;
        rvalid_d = (state_q == ACC_READ);
      end
      default: state_d = ACC_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      state_q <= ACC_IDLE;
      rvalid_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      rvalid_q <= rvalid_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Overvoltage trip level and delta flag
  always_comb
  begin
    ovp_d = overvoltage_reference_select ? voltage_target_maximum_in : voltage_target_in;
    dact_d = (overvoltage_delta_code != `DELTA_OFF_CODE);
    // Sum wraps at 16 bits; real targets stay far below that
    if (dact_d)
      ovp_d = ovp_d + delta_mv(overvoltage_delta_code);
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      ovp_q <= `TRIP_MV_RESET;
      dact_q <= 1'b0;
    end
    else
    begin
      ovp_q <= ovp_d;
      dact_q <= dact_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Over-temperature trip point
  always_comb
  begin
    if (otp_source_select)
      otp_d = code_to_c(otp_code);
    else
      otp_d = proc_otp_c_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
      otp_q <= `TEMP_RESET;
    else
      otp_q <= otp_d;
  end

  //////////////////////////////////////////////////////////////////////
  // Hot-warning threshold and enable
  always_comb
  begin
    if (hot_warning_source_select)
    begin
      hot_d = code_to_c(hot_code);
      hot_en_d = (hot_code != `HOT_OFF_CODE);
    end
    else
    begin
      hot_d = proc_hot_c_in;
      hot_en_d = proc_hot_en_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      hot_q <= `TEMP_RESET;
      hot_en_q <= 1'b0;
    end
    else
    begin
      hot_q <= hot_d;
      hot_en_q <= hot_en_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read answer: rvalid from a flop, data from the store's register
  assign acc_rvalid_out = rvalid_q;
  assign acc_rdata_out = rdata;
  // Derived settings, all registered above
  assign overvoltage_trip_mv_out = ovp_q;
  assign overvoltage_delta_active_out = dact_q;
  assign overtemp_trip_c_out = otp_q;
  assign regulator_hot_warning_c_out = hot_q;
  assign regulator_hot_warning_en_out = hot_en_q;
endmodule
`default_nettype wire

/* File: tb/protection_threshold_regs_chk.sv */
/* Port checker for the threshold registers.
   Assumes bind to the top module by port names. */
`timescale 1ns/100ps
`default_nettype none
module protection_threshold_regs_chk
  import protection_threshold_pkg::*;
(
  // Ports seen
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic acc_valid_in,
  input wire logic acc_write_in,
  input wire logic [7:0] acc_addr_in,
  input wire logic [7:0] acc_wdata_in,
  input wire logic acc_rvalid_out,
  input wire logic [7:0] acc_rdata_out,
  input wire millivolt_t voltage_target_in,
  input wire millivolt_t voltage_target_maximum_in,
  input wire temp_c_t proc_otp_c_in,
  input wire temp_c_t proc_hot_c_in,
  input wire logic proc_hot_en_in,
  input wire millivolt_t overvoltage_trip_mv_out,
  input wire logic overvoltage_delta_active_out,
  input wire temp_c_t overtemp_trip_c_out,
  input wire temp_c_t regulator_hot_warning_c_out,
  input wire logic regulator_hot_warning_en_out
);
  logic [7:0] c_q;
  logic [7:0] o_q;
  logic [7:0] h_q;
  logic w;
  ////////////////////////////////////////////////////////////////
  // Shadow copies, so outputs are judged against writes
  assign w = acc_valid_in && acc_write_in;
  always_ff @(posedge clk_in)
  begin
    c_q <= !rst_b_in ? 8'h00 : w && acc_addr_in == 8'h16 ? acc_wdata_in & 8'hF3 : c_q;
    o_q <= !rst_b_in ? 8'hA5 : w && acc_addr_in == 8'h17 ? acc_wdata_in : o_q;
    h_q <= !rst_b_in ? 8'h8C : w && acc_addr_in == 8'h18 ? acc_wdata_in : h_q;
  end
  millivolt_t ov_e;
  temp_c_t ot_e;
  temp_c_t hc_e;
  logic he_e;
  logic dl_e;
  logic [7:0] rd_e;
  assign ov_e = 16'((c_q[7] ? voltage_target_maximum_in : voltage_target_in) + c_q[6:4] * 16'h015E);
  assign dl_e = c_q[6:4] != 3'h0;
  assign ot_e = c_q[0] ? temp_c_t'({1'b0, o_q}) - 9'sh028 : proc_otp_c_in;
  assign hc_e = c_q[1] ? temp_c_t'({1'b0, h_q}) - 9'sh028 : proc_hot_c_in;
  assign he_e = c_q[1] ? h_q != 8'h00 : proc_hot_en_in;
  assign rd_e = acc_addr_in == 8'h16 ? c_q : acc_addr_in == 8'h17 ? o_q : acc_addr_in == 8'h18 ? h_q : 8'h00;
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  AST_OV_TRIP:
    assert property ($past(rst_b_in) |-> overvoltage_trip_mv_out == $past(ov_e)) else $error("trip level wrong");
  AST_DELTA_ON:
    assert property ($past(rst_b_in) |-> overvoltage_delta_active_out == $past(dl_e)) else $error("delta flag wrong");
  AST_HOT_LVL:
    assert property ($past(rst_b_in) |-> regulator_hot_warning_c_out == $past(hc_e)) else $error("hot level wrong");
  AST_OT_TRIP:
    assert property ($past(rst_b_in) |-> overtemp_trip_c_out == $past(ot_e)) else $error("overtemp wrong");
  AST_HOT_EN:
    assert property ($past(rst_b_in) |-> regulator_hot_warning_en_out == $past(he_e)) else $error("hot enable wrong");
  AST_READ:
    assert property (acc_rvalid_out |-> acc_rdata_out == $past(rd_e)) else $error("read data wrong");
  cover property (acc_rvalid_out && acc_rdata_out == 8'hF3);
  cover property (overvoltage_delta_active_out);
  cover property (regulator_hot_warning_en_out ##1 !regulator_hot_warning_en_out);
endmodule
bind protection_threshold_regs protection_threshold_regs_chk u_chk (.*);
`default_nettype wire

/* File: tb/host_access_model.sv */
/* Host model issuing byte accesses.
   Assumes tasks are called from the bench top. */
`timescale 1ns/100ps
`default_nettype none
module host_access_model
(
  // Clock
  input wire logic clk_in,
  // Access
  output logic valid_out = 1'b0,
  output logic write_out = 1'b0,
  output logic [7:0] addr_out = 8'h00,
  output logic [7:0] wdata_out = 8'h00,
  input wire logic rvalid_in,
  input wire logic [7:0] rdata_in
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    valid_out <= 1'b1;
    write_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    valid_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  // Address held until the answer, fixed two-edge latency
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    valid_out <= 1'b1;
    write_out <= 1'b0;
    addr_out <= a;
    @(posedge clk_in);
    valid_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    d = rvalid_in ? rdata_in : 8'hxx;
    addr_out <= ~a;
  endtask
endmodule
`default_nettype wire

/* File: tb/protection_threshold_regs_tb_top.sv */
/* Bench for the threshold registers.
   Assumes the host model and bound checker. */
`timescale 1ns/100ps
`default_nettype none
module protection_threshold_regs_tb_top;
  import protection_threshold_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic phe = 1'b1;
  logic valid, write, rvalid, da, he;
  logic [7:0] addr, wdata, rdata, d;
  millivolt_t v = 16'h03E8;
  millivolt_t vm = 16'h05DC;
  millivolt_t ov;
  temp_c_t po = 9'sh06E;
  temp_c_t ph = 9'sh05F;
  temp_c_t ot, hc;
  int fail_count = 0;
  int num_checks = 0;
  always #20 clk_in = ~clk_in;
  host_access_model u_host (.clk_in(clk_in), .valid_out(valid), .write_out(write), .addr_out(addr),
    .wdata_out(wdata), .rvalid_in(rvalid), .rdata_in(rdata));
  protection_threshold_regs u_protection_threshold_regs (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .acc_valid_in(valid), .acc_write_in(write), .acc_addr_in(addr), .acc_wdata_in(wdata),
    .acc_rvalid_out(rvalid), .acc_rdata_out(rdata), .voltage_target_in(v), .voltage_target_maximum_in(vm),
    .proc_otp_c_in(po), .proc_hot_c_in(ph), .proc_hot_en_in(phe), .overvoltage_trip_mv_out(ov),
    .overvoltage_delta_active_out(da), .overtemp_trip_c_out(ot), .regulator_hot_warning_c_out(hc),
    .regulator_hot_warning_en_out(he));
  task automatic chk(input string n, input logic signed [15:0] e, input logic signed [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    u_host.rd(8'h16, d);
    chk("ctrl", 8'h00, d);
    u_host.rd(8'h17, d);
    chk("otp", 8'hA5, d);
    u_host.rd(8'h18, d);
    chk("hot", 8'h8C, d);
    u_host.rd(8'h20, d);
    chk("unmapped", 8'h00, d);
    chk("ov", v, ov);
    chk("hc", ph, hc);
    chk("he", phe, he);
    chk("ot", po, ot);
  endtask
  task automatic t_delta;
    for (int i = 0; i < 16; i++)
    begin
      u_host.wr(8'h16, {i[3:0], 4'hF});
      repeat (2) @(posedge clk_in);
      chk("ov", (i[3] ? vm : v) + 16'(i[2:0]) * 16'h015E, ov);
      chk("delta", 16'(i[2:0] != 0), 16'(da));
    end
    u_host.rd(8'h16, d);
    chk("ctrl", 8'hF3, d);
    chk("ot", 9'sh07D, ot);
    chk("hc", 9'sh064, hc);
    chk("he", 1'b1, he);
  endtask
  task automatic t_local;
    u_host.wr(8'h18, 8'h00);
    u_host.wr(8'h17, 8'h00);
    repeat (2) @(posedge clk_in);
    chk("he", 1'b0, he);
    chk("ot", 9'sh1D8, ot);
    u_host.wr(8'h16, 8'h00);
    repeat (2) @(posedge clk_in);
    chk("he", 1'b1, he);
    chk("ot", po, ot);
    phe <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk("he", 1'b0, he);
  endtask
  initial
  begin
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_reset();
    t_delta();
    t_local();
    give_verdict();
  end
  initial
  begin
    repeat (3000) @(posedge clk_in);
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
